//--- hw/dio_pkg.sv
package dio_pkg;

    // Object indices and subindices of the configuration entries
    localparam logic [15:0] IDX_IN_CFG      = 16'h3240;
    localparam logic [15:0] IDX_IN_ROUTE    = 16'h3242;
    localparam logic [15:0] IDX_OUT_CFG     = 16'h3250;
    localparam logic [15:0] IDX_OUT_ROUTE   = 16'h3252;
    localparam logic [15:0] IDX_IN_STATE    = 16'h60FD;
    localparam logic [15:0] IDX_OUT_CMD     = 16'h60FE;

    localparam logic [7:0]  SUB_IN_FUNC_EN  = 8'h01;
    localparam logic [7:0]  SUB_IN_INVERT   = 8'h02;
    localparam logic [7:0]  SUB_IN_FORCE_EN = 8'h03;
    localparam logic [7:0]  SUB_IN_FORCE_VL = 8'h04;
    localparam logic [7:0]  SUB_IN_RAW      = 8'h05;
    localparam logic [7:0]  SUB_ROUTE_EN    = 8'h08;
    localparam logic [7:0]  SUB_OUT_POL     = 8'h02;
    localparam logic [7:0]  SUB_OUT_MAN_SEL = 8'h03;
    localparam logic [7:0]  SUB_OUT_MAN_VAL = 8'h04;
    localparam logic [7:0]  SUB_OUT_APPLIED = 8'h05;
    localparam logic [7:0]  SUB_STATE_WORD  = 8'h00;
    localparam logic [7:0]  SUB_CMD_WORD    = 8'h01;
    localparam logic [7:0]  SUB_TABLE_FIRST = 8'h01;

    // Bit layout of the state and command words
    localparam int          LEVEL_BASE      = 16;
    localparam int          BRAKE_BIT       = 0;
    localparam int          SPECIAL_INPUTS  = 3;
    localparam int          IN_TABLE_DEPTH  = 32;

    // Input source codes
    localparam logic [6:0]  SRC_CONST       = 7'h00;
    localparam logic [6:0]  SRC_DIN_FIRST   = 7'h01;
    localparam logic [6:0]  SRC_DIN_LAST    = 7'h10;
    localparam logic [6:0]  SRC_AUX_FIRST   = 7'h41;
    localparam logic [6:0]  SRC_AUX_LAST    = 7'h46;
    localparam logic [6:0]  SRC_LINK        = 7'h48;
    localparam int          SRC_INV_BIT     = 7;

    // Output route entry layout and source codes
    localparam int          ROUTE_SRC_LSB   = 8;
    localparam int          ROUTE_GATE_INV  = 7;
    localparam logic [7:0]  OSRC_ONE        = 8'h00;
    localparam logic [7:0]  OSRC_ZERO       = 8'h01;

    // Sampling period of the digital inputs
    localparam longint      CLK_PERIOD_PS   = 100000;
    localparam longint      SAMPLE_PERIOD_PS = 1000000000;
    localparam int          SAMPLE_CYCLES   =
        int'(SAMPLE_PERIOD_PS / CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b00,
        ST_PRELOAD = 2'b01,
        ST_ROUTED  = 2'b10
    } dio_in_mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } dio_od_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } dio_od_rsp_t;

endpackage

//--- hw/dio_route_mem.sv
`timescale 1ns/1ps
module dio_route_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             i_clk,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset: contents are always preloaded before use
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end

endmodule

//--- hw/dio_in_sampler.sv
`timescale 1ns/1ps
module dio_in_sampler #(
    parameter int WIDTH  = 23,
    parameter int PERIOD = 10000
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_in,
    output logic      [WIDTH-1:0] o_out
);

    logic [$clog2(PERIOD)-1:0] tick_cnt;
    logic [WIDTH-1:0]          last_sample;
    logic                      tick;

    assign tick = (tick_cnt == ($clog2(PERIOD))'(PERIOD - 1));

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // A level must agree on two ticks, so a shorter pulse is never taken
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            last_sample <= '0;
            o_out       <= '0;
        end else if (tick) begin
            last_sample <= i_in;
            for (int b = 0; b < WIDTH; b++) begin
                if (i_in[b] == last_sample[b]) begin
                    o_out[b] <= i_in[b];
                end
            end
        end
    end

endmodule

//--- hw/dio_top.sv
`timescale 1ns/1ps
// Operation
// - Writing input routing enable 1 enters routing; clearing it leaves.
// - In routing mode, input enable, invert and force entries do nothing.
// - Entering routing preloads the table to keep the normal behaviour of unforced inputs.
// - Input table entry n selects the source of state bit n-1.
// - Codes 00, 01-10, 41-46, 48 pick zero, inputs, Hall, encoder, link.
// - Code bit 7 inverts the selected source; 80h gives constant one.
// - Physical output k follows command word bit 15+k.
// - Command bits 0-15 are special; bit 0 drives the brake.
// - Polarity bit picks normally open or normally closed output.
// - Manual select bit takes the output from the manual value bit.
// - The applied output pattern is readable in the applied entry.
// - Routing mode feeds each output its source gated by a command bit.
// - Route entry high byte selects source, low byte selects gate bit.
// - Writing output routing enable to 1 enables output routing.
// - In output routing, polarity and manual entries have no effect.
// - Route low byte bit 7 set makes a zero gate bit switch on.
// - Inputs are sampled every millisecond; shorter pulses are ignored.
module dio_top
    import dio_pkg::*;
#(
    parameter int N_DIN       = 16,
    parameter int N_OUT       = 4,
    parameter int SAMPLE_CYC  = dio_pkg::SAMPLE_CYCLES
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire logic [N_DIN-1:0]      i_din,
    input  wire logic [2:0]            i_hall,
    input  wire logic [2:0]            i_enc,
    input  wire logic                  i_link_active,
    input  wire dio_pkg::dio_od_req_t  i_od_req,
    output dio_pkg::dio_od_rsp_t       o_od_rsp,
    output logic      [N_OUT-1:0]      o_dout,
    output logic                       o_brake
);
    import dio_pkg::*;

    localparam int NSRC = N_DIN + 7;
    localparam int NRT  = N_OUT + 1;
    localparam int TAW  = $clog2(IN_TABLE_DEPTH);

    logic [NSRC-1:0]  flt;
    logic [N_DIN-1:0] din_flt;
    logic [31:0]      in_func_en;
    logic [31:0]      in_invert;
    logic [31:0]      in_force_en;
    logic [31:0]      in_force_val;
    logic             in_route_en;
    logic [31:0]      out_pol;
    logic [31:0]      out_man_sel;
    logic [31:0]      out_man_val;
    logic             out_route_en;
    logic [15:0]      out_route [NRT];
    logic [31:0]      cmd_word;
    logic [31:0]      state_word;
    logic [31:0]      applied;
    dio_in_mode_t     in_mode;
    logic [TAW-1:0]   pre_idx;
    logic [TAW-1:0]   scan_idx;
    logic [TAW-1:0]   scan_bit;
    logic             scan_vld;
    logic [7:0]       tbl_rdata;
    logic             tbl_we;
    logic [TAW-1:0]   tbl_waddr;
    logic [7:0]       tbl_wdata;
    logic [TAW-1:0]   tbl_raddr;
    logic [7:0]       pre_code;
    logic [31:0]      next_normal;
    logic [31:0]      next_applied;
    logic             wr;
    logic             rd;
    logic             hit_tbl_r;
    logic             hit_tbl_w;
    logic [7:0]       tsub;
    logic             rd_stage;
    logic             rd_is_tbl;
    logic             rd_err;
    logic             wr_stage;
    logic             wr_err;
    logic [31:0]      rd_hold;
    logic [31:0]      rd_mux;
    logic             rd_ok;
    logic             wr_ok;

    dio_in_sampler #(
        .WIDTH  (NSRC),
        .PERIOD (SAMPLE_CYC)
    ) u_sampler (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_in    ({i_link_active, i_enc, i_hall, i_din}),
        .o_out   (flt)
    );

    assign din_flt = flt[N_DIN-1:0];

    dio_route_mem #(
        .DEPTH (IN_TABLE_DEPTH),
        .WIDTH (8)
    ) u_in_table (
        .i_clk   (i_clk),
        .i_we    (tbl_we),
        .i_waddr (tbl_waddr),
        .i_wdata (tbl_wdata),
        .i_raddr (tbl_raddr),
        .o_rdata (tbl_rdata)
    );

    // Source decode of one input table entry
    function automatic logic src_value(input logic [7:0] code,
                                       input logic [NSRC-1:0] s);
        logic [6:0] c;
        logic       v;
        logic       ok;
        c  = code[6:0];
        v  = 1'b0;
        ok = 1'b1;
        if (c == SRC_CONST) begin
            v = 1'b0;
        end else if (c >= SRC_DIN_FIRST && c <= SRC_DIN_LAST
                     && int'(c) <= N_DIN) begin
            v = s[int'(c - SRC_DIN_FIRST)];
        end else if (c >= SRC_AUX_FIRST && c <= SRC_AUX_LAST) begin
            v = s[N_DIN + int'(c - SRC_AUX_FIRST)];
        end else if (c == SRC_LINK) begin
            v = s[NSRC-1];
        end else begin
            ok = 1'b0;
        end
        return ok & (v ^ code[SRC_INV_BIT]);
    endfunction

    assign wr   = i_od_req.wr;
    assign rd   = i_od_req.rd;
    assign tsub = i_od_req.sub - SUB_TABLE_FIRST;
    assign hit_tbl_r = i_od_req.index == IDX_IN_ROUTE
                       && i_od_req.sub >= SUB_TABLE_FIRST
                       && i_od_req.sub <= 8'(IN_TABLE_DEPTH);
    assign hit_tbl_w = hit_tbl_r;

    // Normal-mode input state word
    always_comb begin
        next_normal = '0;
        for (int k = 0; k < N_DIN; k++) begin
            next_normal[LEVEL_BASE + k] = in_force_en[k] ? in_force_val[k]
                                        : din_flt[k] ^ in_invert[k];
        end
        for (int k = 0; k < SPECIAL_INPUTS; k++) begin
            next_normal[k] = next_normal[LEVEL_BASE + k] & in_func_en[k];
        end
    end

    // preload code mirrors the normal-mode function of unforced inputs
    always_comb begin
        pre_code = 8'h00;
        if (int'(pre_idx) >= LEVEL_BASE
            && int'(pre_idx) < LEVEL_BASE + N_DIN) begin
            pre_code = {in_invert[int'(pre_idx) - LEVEL_BASE],
                        7'(int'(pre_idx) - LEVEL_BASE + 1)};
        end else if (int'(pre_idx) < SPECIAL_INPUTS
                     && in_func_en[pre_idx]) begin
            pre_code = {in_invert[pre_idx], 7'(int'(pre_idx) + 1)};
        end
    end

    always_comb begin
        tbl_we    = 1'b0;
        tbl_waddr = tsub[TAW-1:0];
        tbl_wdata = i_od_req.wdata[7:0];
        if (in_mode == ST_PRELOAD) begin
            tbl_we    = 1'b1;
            tbl_waddr = pre_idx;
            tbl_wdata = pre_code;
        end else if (wr && hit_tbl_w) begin
            tbl_we    = 1'b1;
        end
    end

    // Software reads borrow the table port; the scan pauses meanwhile
    assign tbl_raddr = (rd && hit_tbl_r) ? tsub[TAW-1:0] : scan_idx;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            in_mode <= ST_NORMAL;
            pre_idx <= '0;
        end else begin
            case (in_mode)
                ST_NORMAL: begin
                    pre_idx <= '0;
                    if (in_route_en) begin
                        in_mode <= ST_PRELOAD;
                    end
                end
                ST_PRELOAD: begin
                    pre_idx <= pre_idx + 1'b1;
                    if (!in_route_en) begin
                        in_mode <= ST_NORMAL;
                    end else if (pre_idx == TAW'(IN_TABLE_DEPTH - 1)) begin
                        in_mode <= ST_ROUTED;
                    end
                end
                ST_ROUTED: begin
                    if (!in_route_en) begin
                        in_mode <= ST_NORMAL;
                    end
                end
                default: in_mode <= ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            scan_idx <= '0;
            scan_bit <= '0;
            scan_vld <= 1'b0;
        end else begin
            scan_vld <= !(rd && hit_tbl_r);
            scan_bit <= scan_idx;
            if (!(rd && hit_tbl_r)) begin
                scan_idx <= scan_idx + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_word <= '0;
        end else if (in_mode == ST_ROUTED) begin
            if (scan_vld) begin
                state_word[scan_bit] <= src_value(tbl_rdata, flt);
            end
        end else begin
            state_word <= next_normal;
        end
    end

    // Output path, one lane per route entry: lane 0 brake, lane k output k
    always_comb begin
        int          b;
        logic        val;
        logic [7:0]  gsel;
        logic        gate;
        logic        sig;
        b            = 0;
        val          = 1'b0;
        gsel         = 8'h00;
        gate         = 1'b0;
        sig          = 1'b0;
        next_applied = '0;
        for (int k = 0; k < NRT; k++) begin
            // output k uses bit 15+k; lane 0 is brake
            b = (k == 0) ? BRAKE_BIT : LEVEL_BASE + k - 1;
            if (out_route_en) begin
                // high byte source, low byte gate
                gsel = out_route[k][7:0];
                // gate sense inverted by bit 7
                gate = cmd_word[gsel[4:0]] ^ gsel[ROUTE_GATE_INV];
                sig  = (out_route[k][15:ROUTE_SRC_LSB] == OSRC_ONE);
                // routed source gated by command bit
                val  = sig & gate;
            end else begin
                val = out_man_sel[b] ? out_man_val[b] : cmd_word[b];
                val = val ^ out_pol[b];
            end
            next_applied[b] = val;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            applied <= '0;
            o_dout  <= '0;
            o_brake <= 1'b0;
        end else begin
            applied <= next_applied;
            o_dout  <= next_applied[LEVEL_BASE +: N_OUT];
            o_brake <= next_applied[BRAKE_BIT];
        end
    end

    // Writable entries
    // reset clears enables and selects
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            in_func_en   <= '0;
            in_invert    <= '0;
            in_force_en  <= '0;
            in_force_val <= '0;
            in_route_en  <= 1'b0;
            out_pol      <= '0;
            out_man_sel  <= '0;
            out_man_val  <= '0;
            out_route_en <= 1'b0;
            cmd_word     <= '0;
            for (int k = 0; k < NRT; k++) begin
                out_route[k] <= {OSRC_ZERO, 8'h00};
            end
        end else if (wr) begin
            case (i_od_req.index)
                IDX_IN_CFG: begin
                    case (i_od_req.sub)
                        SUB_IN_FUNC_EN:  in_func_en   <= i_od_req.wdata;
                        SUB_IN_INVERT:   in_invert    <= i_od_req.wdata;
                        SUB_IN_FORCE_EN: in_force_en  <= i_od_req.wdata;
                        SUB_IN_FORCE_VL: in_force_val <= i_od_req.wdata;
                        SUB_ROUTE_EN: in_route_en <= i_od_req.wdata[0];
                        default: ;
                    endcase
                end
                IDX_OUT_CFG: begin
                    case (i_od_req.sub)
                        SUB_OUT_POL:     out_pol     <= i_od_req.wdata;
                        SUB_OUT_MAN_SEL: out_man_sel <= i_od_req.wdata;
                        SUB_OUT_MAN_VAL: out_man_val <= i_od_req.wdata;
                        SUB_ROUTE_EN: out_route_en <= i_od_req.wdata[0];
                        default: ;
                    endcase
                end
                IDX_OUT_ROUTE: begin
                    for (int k = 0; k < NRT; k++) begin
                        if (i_od_req.sub == 8'(k + 1)) begin
                            out_route[k] <= i_od_req.wdata[15:0];
                        end
                    end
                end
                IDX_OUT_CMD: begin
                    if (i_od_req.sub == SUB_CMD_WORD) begin
                        cmd_word <= i_od_req.wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    // Read decode for everything outside the table
    always_comb begin
        rd_mux = '0;
        rd_ok  = 1'b1;
        case ({i_od_req.index, i_od_req.sub})
            {IDX_IN_CFG, SUB_IN_FUNC_EN}:   rd_mux = in_func_en;
            {IDX_IN_CFG, SUB_IN_INVERT}:    rd_mux = in_invert;
            {IDX_IN_CFG, SUB_IN_FORCE_EN}:  rd_mux = in_force_en;
            {IDX_IN_CFG, SUB_IN_FORCE_VL}:  rd_mux = in_force_val;
            {IDX_IN_CFG, SUB_IN_RAW}:       rd_mux = 32'(din_flt);
            {IDX_IN_CFG, SUB_ROUTE_EN}:     rd_mux = 32'(in_route_en);
            {IDX_OUT_CFG, SUB_OUT_POL}:     rd_mux = out_pol;
            {IDX_OUT_CFG, SUB_OUT_MAN_SEL}: rd_mux = out_man_sel;
            {IDX_OUT_CFG, SUB_OUT_MAN_VAL}: rd_mux = out_man_val;
            {IDX_OUT_CFG, SUB_OUT_APPLIED}: rd_mux = applied;
            {IDX_OUT_CFG, SUB_ROUTE_EN}:    rd_mux = 32'(out_route_en);
            {IDX_IN_STATE, SUB_STATE_WORD}: rd_mux = state_word;
            {IDX_OUT_CMD, SUB_CMD_WORD}:    rd_mux = cmd_word;
            default: begin
                rd_ok = 1'b0;
                for (int k = 0; k < NRT; k++) begin
                    if (i_od_req.index == IDX_OUT_ROUTE
                        && i_od_req.sub == 8'(k + 1)) begin
                        rd_mux = 32'(out_route[k]);
                        rd_ok  = 1'b1;
                    end
                end
            end
        endcase
    end

    assign wr_ok = rd_ok || hit_tbl_w;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_stage  <= 1'b0;
            rd_is_tbl <= 1'b0;
            rd_err    <= 1'b0;
            wr_stage  <= 1'b0;
            wr_err    <= 1'b0;
            rd_hold   <= '0;
            o_od_rsp  <= '0;
        end else begin
            rd_stage  <= rd && !wr;
            rd_is_tbl <= hit_tbl_r;
            rd_err    <= !(rd_ok || hit_tbl_r);
            rd_hold   <= rd_mux;
            wr_stage  <= wr;
            wr_err    <= !wr_ok;
            // Uniform two-cycle answer, so the table read lines up
            o_od_rsp.ack   <= rd_stage || wr_stage;
            o_od_rsp.err   <= (rd_stage && rd_err) || (wr_stage && wr_err);
            o_od_rsp.rdata <= !rd_stage ? 32'h0000_0000
                            : rd_is_tbl ? 32'(tbl_rdata) : rd_hold;
        end
    end

endmodule

//--- test/dio_partner.sv
`timescale 1ns/1ps
module dio_partner (
    input  wire logic        i_clk,
    output logic      [15:0] o_din,
    output logic      [2:0]  o_hall,
    output logic      [2:0]  o_enc,
    output logic             o_link
);
    logic [22:0] lvl = 23'h0;
    // Switches hold their level between changes
    assign {o_link, o_enc, o_hall, o_din} = lvl;
    task automatic apply(logic [22:0] v);
        @(negedge i_clk);
        lvl = v;
    endtask
    task automatic pulse(int b, int n);
        @(negedge i_clk);
        lvl[b] = ~lvl[b];
        repeat (n) @(negedge i_clk);
        lvl[b] = ~lvl[b];
    endtask
endmodule

//--- test/dio_checker.sv
`timescale 1ns/1ps
module dio_checker
    import dio_pkg::*;
#(
    parameter int N_OUT = 4
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire dio_pkg::dio_od_req_t i_od_req,
    input  wire dio_pkg::dio_od_rsp_t o_od_rsp,
    input  wire logic [N_OUT-1:0]     o_dout,
    input  wire logic                 o_brake
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic req;
    logic known;
    assign req = i_od_req.wr | i_od_req.rd;
    assign known = i_od_req.index inside {IDX_IN_CFG, IDX_IN_ROUTE,
        IDX_OUT_CFG, IDX_OUT_ROUTE, IDX_IN_STATE, IDX_OUT_CMD};
    chk_ack_latency:
        assert property (req |-> ##2 o_od_rsp.ack) else $error("no ack");
    chk_ack_cause:
        assert property (o_od_rsp.ack |-> $past(req, 2))
        else $error("stray ack");
    chk_err_unmapped:
        assert property (req && !known |-> ##2 o_od_rsp.err)
        else $error("unmapped not refused");
    chk_ro_write_ok:
        assert property (i_od_req.wr && i_od_req.index == IDX_IN_STATE
            |-> ##2 o_od_rsp.ack && !o_od_rsp.err)
        else $error("read-only write refused");
    chk_err_with_ack:
        assert property (o_od_rsp.err |-> o_od_rsp.ack)
        else $error("err without ack");
    chk_rdata_quiet:
        assert property (!o_od_rsp.ack |-> o_od_rsp.rdata == '0)
        else $error("rdata outside ack");
    chk_dout_cause:
        assert property ($changed(o_dout) |-> $past(i_od_req.wr, 2))
        else $error("output moved without write");
    chk_brake_cause:
        assert property ($changed(o_brake) |-> $past(i_od_req.wr, 2))
        else $error("brake moved without write");
    chk_applied_read:
        assert property (i_od_req.rd && i_od_req.index == IDX_OUT_CFG
            && i_od_req.sub == SUB_OUT_APPLIED |-> ##2
            o_od_rsp.rdata[16 +: N_OUT] == o_dout
            && o_od_rsp.rdata[0] == o_brake)
        else $error("applied entry differs from pins");
endmodule
bind dio_top dio_checker #(.N_OUT(N_OUT)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_od_req(i_od_req),
    .o_od_rsp(o_od_rsp), .o_dout(o_dout), .o_brake(o_brake));

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dio_pkg::*;
    logic        i_clk = 0;
    logic        i_rst_b = 0;
    dio_od_req_t req = '0;
    dio_od_rsp_t rsp;
    logic [15:0] din;
    logic [2:0]  hall;
    logic [2:0]  enc;
    logic        link;
    logic [3:0]  dout;
    logic        brake;
    logic [31:0] rdv;
    logic [22:0] lv = 23'h55A5C3;
    int          bad_count = 0;
    int          cmp_count = 0;
    always #50 i_clk = ~i_clk;
    dio_partner u_env (.i_clk(i_clk), .o_din(din), .o_hall(hall),
        .o_enc(enc), .o_link(link));
    dio_top #(.SAMPLE_CYC(8)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_din(din), .i_hall(hall), .i_enc(enc), .i_link_active(link),
        .i_od_req(req), .o_od_rsp(rsp), .o_dout(dout), .o_brake(brake));
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(logic w, logic [15:0] ix, logic [7:0] sb,
                       logic [31:0] d, logic er = 1'b0);
        @(negedge i_clk);
        req = '{wr: w, rd: !w, index: ix, sub: sb, wdata: d};
        @(negedge i_clk);
        req = '0;
        @(negedge i_clk);
        chk("ack", 32'(1'b1), 32'(rsp.ack));
        chk("err", 32'(er), 32'(rsp.err));
        rdv = rsp.rdata;
    endtask
    task automatic wr(logic [15:0] ix, logic [7:0] sb, logic [31:0] d);
        acc(1'b1, ix, sb, d);
    endtask
    task automatic rd(logic [15:0] ix, logic [7:0] sb, logic [31:0] e);
        acc(1'b0, ix, sb, 32'h0);
        chk("rdata", e, rdv);
    endtask
    task automatic outs(logic [3:0] e, logic b);
        chk("dout", 32'(e), 32'(dout));
        chk("brake", 32'(b), 32'(brake));
    endtask
    function automatic logic [7:0] code(int i);
        if (i < 16) return 8'(i + 1);
        if (i < 22) return 8'(8'h41 + i - 16);
        if (i < 24) return (i == 22) ? 8'h48 : 8'h80;
        if (i < 30) return 8'(8'hC1 + i - 24);
        return (i == 30) ? 8'hC8 : 8'h47;
    endfunction
    function automatic logic srcv(logic [7:0] c);
        logic [6:0] b;
        b = c[6:0];
        if (b == 7'h00) return c[7];
        if (b <= 7'h10) return lv[b - 7'h01] ^ c[7];
        if (b >= 7'h41 && b <= 7'h46) return lv[b - 7'h31] ^ c[7];
        if (b == 7'h48) return lv[22] ^ c[7];
        return 1'b0;
    endfunction
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        summarize();
    end
    initial begin
        logic [31:0] w;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_b = 1;
        rd(IDX_OUT_CFG, SUB_OUT_POL, 32'h0);
        rd(IDX_OUT_CFG, SUB_OUT_MAN_SEL, 32'h0);
        rd(IDX_IN_CFG, SUB_ROUTE_EN, 32'h0);
        rd(IDX_OUT_CFG, SUB_ROUTE_EN, 32'h0);
        wr(IDX_OUT_CMD, SUB_CMD_WORD, 32'h0001_0001);
        outs(4'h1, 1'b1);
        wr(IDX_OUT_CMD, SUB_CMD_WORD, 32'h0002_0000);
        outs(4'h2, 1'b0);
        wr(IDX_OUT_CFG, SUB_OUT_POL, 32'h0001_0000);
        outs(4'h3, 1'b0);
        wr(IDX_OUT_CFG, SUB_OUT_MAN_SEL, 32'h0004_0001);
        wr(IDX_OUT_CFG, SUB_OUT_MAN_VAL, 32'h0004_0000);
        outs(4'h7, 1'b0);
        rd(IDX_OUT_CFG, SUB_OUT_APPLIED, 32'h0007_0000);
        wr(IDX_OUT_CFG, SUB_ROUTE_EN, 32'h1);
        outs(4'h0, 1'b0);
        wr(IDX_OUT_ROUTE, 8'h02, 32'h0005);
        wr(IDX_OUT_ROUTE, 8'h03, 32'h0085);
        outs(4'h2, 1'b0);
        wr(IDX_OUT_CMD, SUB_CMD_WORD, 32'h0000_0020);
        outs(4'h1, 1'b0);
        wr(IDX_OUT_ROUTE, 8'h01, 32'h0080);
        outs(4'h1, 1'b1);
        rd(IDX_OUT_ROUTE, 8'h02, 32'h0005);
        wr(IDX_OUT_CFG, SUB_ROUTE_EN, 32'h0);
        outs(4'h5, 1'b0);
        u_env.apply(lv);
        repeat (40) @(negedge i_clk);
        rd(IDX_IN_STATE, SUB_STATE_WORD, 32'hA5C3_0000);
        u_env.pulse(0, 5);
        repeat (40) @(negedge i_clk);
        rd(IDX_IN_STATE, SUB_STATE_WORD, 32'hA5C3_0000);
        wr(IDX_IN_CFG, SUB_IN_INVERT, 32'h1);
        wr(IDX_IN_CFG, SUB_IN_FUNC_EN, 32'h7);
        rd(IDX_IN_STATE, SUB_STATE_WORD, 32'hA5C2_0002);
        rd(IDX_IN_CFG, SUB_IN_RAW, 32'h0000_A5C3);
        wr(IDX_IN_CFG, SUB_ROUTE_EN, 32'h1);
        repeat (80) @(negedge i_clk);
        rd(IDX_IN_STATE, SUB_STATE_WORD, 32'hA5C2_0002);
        rd(IDX_IN_ROUTE, 8'h11, 32'h0000_0081);
        rd(IDX_IN_ROUTE, 8'h02, 32'h0000_0002);
        wr(IDX_IN_CFG, SUB_IN_INVERT, 32'h0);
        wr(IDX_IN_CFG, SUB_IN_FUNC_EN, 32'h0);
        wr(IDX_IN_CFG, SUB_IN_FORCE_EN, 32'hFFFF);
        rd(IDX_IN_STATE, SUB_STATE_WORD, 32'hA5C2_0002);
        for (int i = 0; i < 32; i++) begin
            wr(IDX_IN_ROUTE, 8'(i + 1), 32'(code(i)));
            w[i] = srcv(code(i));
        end
        repeat (80) @(negedge i_clk);
        rd(IDX_IN_STATE, SUB_STATE_WORD, w);
        chk("route_word", w, rdv);
        wr(IDX_IN_CFG, SUB_IN_FORCE_EN, 32'h0);
        wr(IDX_IN_CFG, SUB_ROUTE_EN, 32'h0);
        rd(IDX_IN_STATE, SUB_STATE_WORD, 32'hA5C3_0000);
        acc(1'b0, 16'h1234, 8'h00, 32'h0, 1'b1);
        acc(1'b1, IDX_IN_STATE, SUB_STATE_WORD, 32'hFFFF_FFFF);
        rd(IDX_OUT_CFG, SUB_OUT_APPLIED, 32'h0005_0000);
        summarize();
    end
endmodule
